// ### hw/supv_timer_pkg.sv
// constants and types for the maintenance and sensor supervision timers
// assumes a single 100 MHz system clock
package supv_timer_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    // interval fields
    localparam int unsigned MD_W = 5;
    localparam logic [4:0] MD_MAX = 5'h1E;
    localparam logic [4:0] MONTH_RST = 5'h06;
    localparam logic [4:0] DAY_RST = 5'h00;
    localparam int unsigned DAYS_PER_MONTH = 30;
    // one day in seconds, as printed for a calendar day
    localparam int unsigned DAY_S = 86400;
    // sensor timer
    localparam int unsigned SENSE_DELAY_MIN = 30;
    localparam logic [5:0] SENSE_MIN_FULL = 6'h1E;
    localparam logic [5:0] SENSE_SEC_FULL = 6'h00;
    localparam int unsigned SEC_CYCLES = CLK_HZ;
    localparam logic [5:0] SEC_LAST = 6'h3B;
    // threshold: 300 counts, about 0.114 % of an 18-bit converter scale
    localparam int unsigned ADC_W = 18;
    localparam logic [17:0] THRESH_RST = 18'h0012C;
    localparam logic SENSE_EN_RST = 1'b1;
    typedef enum logic [1:0] {MAINT_OFF, MAINT_ON, MAINT_ALARM} maint_mode_t;
    typedef enum {CONF_IDLE, CONF_WAIT} confirm_t;
endpackage

// ### hw/supv_timers.sv
// maintenance countdown and sensor-absence timer driving the system alarm
// assumes keypad strobes are one-cycle pulses from logic on sys_clk_i;
// the adc count arrives from another domain and is resynchronised here
//
// Behaviour
// - month and day fields, ceiling thirty
// - interval resets to six months zero days
// - three maintenance modes: off, on, alarm
// - off mode: no countdown, no tag; a latched maintenance alarm holds
// - on mode: expiry shows tag, no alarm
// - alarm mode: zero raises alarm and tag
// - remaining time counts down, readable
// - restart needs reset then confirm; cancel keeps
// - maintenance alarm holds until timer reset
// - adc near zero thirty minutes raises alarm
// - thirty minute delay is fixed
// - threshold adjustable, default 300 counts
// - threshold in raw converter counts
// - detection enable, on after reset
// - sensor timer runs while count below threshold
// - sensor reset reloads full thirty minutes
// - timer reads minutes seconds, full when idle
// - expiry raises alarm, missing and error tags
// - sensor fail clears via reset plus confirm
`timescale 1ns/1ps
module supv_timers
    import supv_timer_pkg::*;
#(
    parameter int unsigned DAY_CYCLES = 32'd864000,
    parameter int unsigned SEC_TICK = supv_timer_pkg::SEC_CYCLES,
    parameter int unsigned MONTH_DAYS = supv_timer_pkg::DAYS_PER_MONTH
)
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // maintenance settings
    input wire logic maint_set_i,
    input wire logic [4:0] maint_month_i,
    input wire logic [4:0] maint_day_i,
    input wire supv_timer_pkg::maint_mode_t maint_mode_i,
    input wire logic maint_reset_req_i,
    // sensor settings
    input wire logic sense_set_i,
    input wire logic sense_en_i,
    input wire logic [17:0] sense_thresh_i,
    input wire logic sense_reset_req_i,
    // confirmation keys
    input wire logic confirm_yes_i,
    input wire logic confirm_no_i,
    // converter
    input wire logic [17:0] adc_count_i,
    // status
    output logic [4:0] set_month_o,
    output logic [4:0] set_day_o,
    output supv_timer_pkg::maint_mode_t mode_o,
    output logic [4:0] left_month_o,
    output logic [4:0] left_day_o,
    output logic maint_tag_o,
    output logic sense_en_o,
    output logic [17:0] sense_thresh_o,
    output logic [5:0] sense_min_o,
    output logic [5:0] sense_sec_o,
    output logic sensor_missing_tag_o,
    output logic sensor_error_tag_o,
    output logic confirm_pending_o,
    output logic sys_alarm_o
);
    import supv_timer_pkg::*;

    function automatic logic [4:0] clamp_md(input logic [4:0] v);
        clamp_md = (v > MD_MAX) ? MD_MAX : v;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // settings
    logic [4:0] set_month_q;
    logic [4:0] set_day_q;
    maint_mode_t mode_q;
    logic sense_en_q;
    logic [17:0] thresh_q;

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            set_month_q <= MONTH_RST;
            set_day_q <= DAY_RST;
            mode_q <= MAINT_ON;
        end
        else if (maint_set_i)
        begin
            set_month_q <= clamp_md(maint_month_i);
            set_day_q <= clamp_md(maint_day_i);
            if (maint_mode_i == MAINT_OFF || maint_mode_i == MAINT_ON
                || maint_mode_i == MAINT_ALARM)
            begin
                mode_q <= maint_mode_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sense_en_q <= SENSE_EN_RST;
            thresh_q <= THRESH_RST;
        end
        else if (sense_set_i)
        begin
            sense_en_q <= sense_en_i;
            thresh_q <= sense_thresh_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // two-step confirmation, one pending request at a time
    confirm_t conf_q;
    logic conf_sense_q;
    logic maint_restart;
    logic sense_restart;

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            conf_q <= CONF_IDLE;
            conf_sense_q <= 1'b0;
        end
        else
        begin
            case (conf_q)
                CONF_IDLE:
                begin
                    if (maint_reset_req_i || sense_reset_req_i)
                    begin
                        conf_q <= CONF_WAIT;
                        conf_sense_q <= sense_reset_req_i;
                    end
                end
                CONF_WAIT:
                begin
                    // cancel returns without touching either timer
                    if (confirm_yes_i || confirm_no_i)
                    begin
                        conf_q <= CONF_IDLE;
                    end
                end
                default:
                begin
                    conf_q <= CONF_IDLE;
                end
            endcase
        end
    end

    assign maint_restart = (conf_q == CONF_WAIT) && confirm_yes_i
        && !conf_sense_q;
    assign sense_restart = (conf_q == CONF_WAIT) && confirm_yes_i
        && conf_sense_q;

    ////////////////////////////////////////////////////////////////////
    // maintenance countdown
    logic [31:0] day_cnt_q;
    logic [4:0] left_month_q;
    logic [4:0] left_day_q;
    logic expired_q;
    logic maint_alarm_q;
    logic day_tick;
    logic zero_left;

    assign zero_left = (left_month_q == 5'h00) && (left_day_q == 5'h00);
    assign day_tick = (day_cnt_q == DAY_CYCLES - 1);

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            day_cnt_q <= '0;
        end
        else if (mode_q == MAINT_OFF || maint_restart || day_tick)
        begin
            day_cnt_q <= '0;
        end
        else
        begin
            day_cnt_q <= day_cnt_q + 32'd1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            left_month_q <= MONTH_RST;
            left_day_q <= DAY_RST;
        end
        else if (maint_restart)
        begin
            left_month_q <= set_month_q;
            left_day_q <= set_day_q;
        end
        else if (mode_q != MAINT_OFF && day_tick && !zero_left)
        begin
            if (left_day_q != 5'h00)
            begin
                left_day_q <= left_day_q - 5'h01;
            end
            else
            begin
                left_month_q <= left_month_q - 5'h01;
                left_day_q <= 5'(MONTH_DAYS - 1);
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            expired_q <= 1'b0;
        end
        else if (maint_restart)
        begin
            expired_q <= 1'b0;
        end
        else if (mode_q != MAINT_OFF && zero_left)
        begin
            expired_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            maint_alarm_q <= 1'b0;
        end
        else if (maint_restart)
        begin
            maint_alarm_q <= 1'b0;
        end
        else if (mode_q == MAINT_ALARM && zero_left)
        begin
            maint_alarm_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // adc resynchroniser, change taken once stages two and three agree
    logic [17:0] adc_s1_q;
    logic [17:0] adc_s2_q;
    logic [17:0] adc_s3_q;
    logic [17:0] adc_q;

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            adc_s1_q <= '0;
            adc_s2_q <= '0;
            adc_s3_q <= '0;
            adc_q <= 18'h3FFFF;
        end
        else
        begin
            adc_s1_q <= adc_count_i;
            adc_s2_q <= adc_s1_q;
            adc_s3_q <= adc_s2_q;
            if (adc_s2_q == adc_s3_q)
            begin
                adc_q <= adc_s3_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sensor-absence timer
    logic near_zero;
    logic [31:0] sec_cnt_q;
    logic [5:0] sense_min_q;
    logic [5:0] sense_sec_q;
    logic sense_fail_q;
    logic sense_run;
    logic sense_zero;

    assign near_zero = (adc_q < thresh_q);
    assign sense_run = sense_en_q && near_zero && !sense_fail_q;
    assign sense_zero = (sense_min_q == 6'h00) && (sense_sec_q == 6'h00);

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sec_cnt_q <= '0;
        end
        else if (!sense_run || sense_restart || sec_cnt_q == SEC_TICK - 1)
        begin
            sec_cnt_q <= '0;
        end
        else
        begin
            sec_cnt_q <= sec_cnt_q + 32'd1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sense_min_q <= SENSE_MIN_FULL;
            sense_sec_q <= SENSE_SEC_FULL;
        end
        else if (sense_restart || (!sense_run && !sense_fail_q))
        begin
            sense_min_q <= SENSE_MIN_FULL;
            sense_sec_q <= SENSE_SEC_FULL;
        end
        else if (sense_run && sec_cnt_q == SEC_TICK - 1 && !sense_zero)
        begin
            if (sense_sec_q != 6'h00)
            begin
                sense_sec_q <= sense_sec_q - 6'h01;
            end
            else
            begin
                sense_min_q <= sense_min_q - 6'h01;
                sense_sec_q <= SEC_LAST;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sense_fail_q <= 1'b0;
        end
        else if (sense_run && sense_zero)
        begin
            sense_fail_q <= 1'b1;
        end
        else if (sense_restart)
        begin
            sense_fail_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign set_month_o = set_month_q;
    assign set_day_o = set_day_q;
    assign mode_o = mode_q;
    assign left_month_o = left_month_q;
    assign left_day_o = left_day_q;
    assign maint_tag_o = expired_q && (mode_q != MAINT_OFF);
    assign sense_en_o = sense_en_q;
    assign sense_thresh_o = thresh_q;
    assign sense_min_o = sense_min_q;
    assign sense_sec_o = sense_sec_q;
    assign sensor_missing_tag_o = sense_fail_q;
    assign sensor_error_tag_o = sense_fail_q;
    assign confirm_pending_o = (conf_q == CONF_WAIT);
    assign sys_alarm_o = maint_alarm_q || sense_fail_q;
endmodule

// ### tb/supv_keypad.sv
// keypad model for the supervision timers
// assumes key codes from the bench, each held one clock:
// 1 maint reset, 2 sensor reset, 3 confirm, 4 cancel
`timescale 1ns/1ps
module supv_keypad
(
    // clock and key code
    input wire logic sys_clk_i,
    input wire logic [2:0] key_i,
    // keypad strobes
    output logic maint_req_o,
    output logic sense_req_o,
    output logic yes_o,
    output logic no_o
);
    logic [2:0] key_q = 3'h0;
    initial {maint_req_o, sense_req_o, yes_o, no_o} = 4'h0;
    always @(posedge sys_clk_i) key_q <= key_i;
    ////////////////////////////////////////////////////////////////////
    // strobes change away from the sampling edge
    always @(negedge sys_clk_i)
    begin
        maint_req_o <= key_q == 3'h1;
        sense_req_o <= key_q == 3'h2;
        yes_o <= key_q == 3'h3;
        no_o <= key_q == 3'h4;
    end
endmodule

// ### tb/supv_timers_chk.sv
// port checks for the supervision timers
// assumes one clock domain, bound to every supv_timers
`timescale 1ns/1ps
module supv_timers_chk
    import supv_timer_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic maint_set_i,
    input wire logic [4:0] maint_month_i,
    input wire logic maint_reset_req_i,
    input wire logic sense_reset_req_i,
    input wire logic confirm_yes_i,
    input wire logic confirm_no_i,
    input wire logic [4:0] set_month_o,
    input wire logic [4:0] set_day_o,
    input wire supv_timer_pkg::maint_mode_t mode_o,
    input wire logic [4:0] left_month_o,
    input wire logic [4:0] left_day_o,
    input wire logic maint_tag_o,
    input wire logic sense_en_o,
    input wire logic [5:0] sense_min_o,
    input wire logic [5:0] sense_sec_o,
    input wire logic sensor_missing_tag_o,
    input wire logic sensor_error_tag_o,
    input wire logic confirm_pending_o,
    input wire logic sys_alarm_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_req;
        maint_reset_req_i && !sense_reset_req_i && !confirm_pending_o;
    endsequence
    sequence s_yes;
        confirm_yes_i && !confirm_no_i;
    endsequence
    ////////////////////////////////////////////////////////////////////
    a_set_month: assert property (maint_set_i && maint_month_i <= 5'h1E
        |=> set_month_o == $past(maint_month_i)) else $error("month lost");
    a_off_quiet: assert property (mode_o == MAINT_OFF |-> !maint_tag_o)
        else $error("tag in off mode");
    a_req_pending: assert property (
        (maint_reset_req_i || sense_reset_req_i) && !confirm_pending_o
        |=> confirm_pending_o) else $error("no confirm step");
    a_restart_walk: assert property (s_req ##1 s_yes |=>
        left_month_o == set_month_o && left_day_o == set_day_o
        && !confirm_pending_o) else $error("restart not loaded");
    a_alarm_hold: assert property (
        sys_alarm_o && !confirm_yes_i && !$past(confirm_yes_i)
        |=> sys_alarm_o) else $error("alarm dropped");
    a_tags_pair: assert property (sensor_missing_tag_o |->
        sensor_error_tag_o && sys_alarm_o) else $error("tags split");
    a_fail_zero: assert property ($rose(sensor_missing_tag_o) |->
        $past(sense_min_o) == 0 && $past(sense_sec_o) == 0)
        else $error("fail before zero");
    a_idle_full: assert property (!sense_en_o [*2] ##0
        !sensor_missing_tag_o |=> sense_min_o == 6'h1E
        && sense_sec_o == 6'h00) else $error("idle not full");
endmodule
bind supv_timers supv_timers_chk u_chk (.*);

// ### tb/supv_timers_test.sv
// self-checking bench for the supervision timers
// assumes the keypad model and shortened tick parameters
`timescale 1ns/1ps
module supv_timers_test;
    import supv_timer_pkg::*;
    localparam int SEC_SIM = 4;
    typedef struct packed
    {
        logic [4:0] m, d;
        maint_mode_t md;
        logic [4:0] em, ed;
        maint_mode_t emd;
    } row_t;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic maint_set_i = 1'b0;
    logic sense_set_i = 1'b0;
    logic sense_en_i = 1'b1;
    logic [4:0] maint_month_i = 5'h00;
    logic [4:0] maint_day_i = 5'h00;
    maint_mode_t maint_mode_i = MAINT_ON;
    logic [17:0] sense_thresh_i = 18'h0012C;
    logic [17:0] adc_count_i = 18'h3FFFF;
    logic [2:0] key = 3'h0;
    logic maint_reset_req_i, sense_reset_req_i, confirm_yes_i, confirm_no_i;
    logic [4:0] set_month_o, set_day_o, left_month_o, left_day_o;
    maint_mode_t mode_o;
    logic maint_tag_o, sense_en_o, sensor_missing_tag_o, sensor_error_tag_o;
    logic confirm_pending_o, sys_alarm_o;
    logic [17:0] sense_thresh_o;
    logic [5:0] sense_min_o, sense_sec_o;
    int err_count = 0;
    int n_tests = 0;
    int i;
    row_t rows [4] = '{'{5'h03, 5'h07, MAINT_ON, 5'h03, 5'h07, MAINT_ON},
        '{5'h1F, 5'h1F, MAINT_OFF, 5'h1E, 5'h1E, MAINT_OFF},
        '{5'h1E, 5'h00, MAINT_ALARM, 5'h1E, 5'h00, MAINT_ALARM},
        '{5'h05, 5'h05, maint_mode_t'(2'h3), 5'h05, 5'h05, MAINT_ALARM}};
    supv_timers #(.DAY_CYCLES(20), .SEC_TICK(SEC_SIM)) uut (.*);
    supv_keypad kp (.sys_clk_i(sys_clk_i), .key_i(key),
        .maint_req_o(maint_reset_req_i), .sense_req_o(sense_reset_req_i),
        .yes_o(confirm_yes_i), .no_o(confirm_no_i));
    always #5 sys_clk_i = ~sys_clk_i;
    ////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask
    // a wait that ran out ends the run
    task automatic bound(input logic ok);
        chk(ok, 1'b1);
        if (ok !== 1'b1)
            wrap_up();
    endtask
    task automatic mset(input logic [4:0] m, d, input maint_mode_t md);
        tick(1);
        maint_set_i = 1'b1;
        maint_month_i = m;
        maint_day_i = d;
        maint_mode_i = md;
        tick(1);
        maint_set_i = 1'b0;
    endtask
    task automatic sset(input logic en, input logic [17:0] th);
        tick(1);
        sense_set_i = 1'b1;
        sense_en_i = en;
        sense_thresh_i = th;
        tick(1);
        sense_set_i = 1'b0;
    endtask
    task automatic press(input logic [2:0] a, b);
        tick(1);
        key = a;
        tick(1);
        key = b;
        tick(1);
        key = 3'h0;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(16);
        nrst_i = 1'b1;
        tick(1);
        chk({set_month_o, set_day_o, left_month_o}, 15'h1806);
        chk({mode_o, sense_en_o, sys_alarm_o}, 4'h6);
        chk(sense_thresh_o, 18'h0012C);
        chk({sense_min_o, sense_sec_o}, 12'h780);
        for (i = 0; i < 4; i++)
        begin
            mset(rows[i].m, rows[i].d, rows[i].md);
            chk({set_month_o, set_day_o}, {rows[i].em, rows[i].ed});
            chk(mode_o, rows[i].emd);
        end
        mset(5'h00, 5'h01, MAINT_OFF);
        press(3'h1, 3'h3);
        tick(61);
        chk({left_day_o, maint_tag_o}, 6'h02);
        mset(5'h00, 5'h01, MAINT_ON);
        for (i = 0; i < 40 && maint_tag_o !== 1'b1; i++) tick(1);
        bound(maint_tag_o);
        tick(5);
        chk({left_day_o, sys_alarm_o}, 6'h00);
        mset(5'h00, 5'h00, MAINT_ALARM);
        for (i = 0; i < 40 && sys_alarm_o !== 1'b1; i++) tick(1);
        bound(sys_alarm_o);
        chk(maint_tag_o, 1'b1);
        press(3'h1, 3'h4);
        chk(confirm_pending_o, 1'b1);
        mset(5'h00, 5'h02, MAINT_ALARM);
        tick(3);
        chk(sys_alarm_o, 1'b1);
        press(3'h1, 3'h3);
        tick(3);
        chk({sys_alarm_o, maint_tag_o}, 2'h0);
        mset(5'h00, 5'h02, MAINT_OFF);
        adc_count_i = 18'h00100;
        tick(40);
        bound(sense_min_o < 6'h1E);
        press(3'h2, 3'h3);
        tick(1);
        chk({sense_min_o, sense_sec_o}, 12'h780);
        for (i = 0; i < 1820 * SEC_SIM && !sensor_missing_tag_o; i++) tick(1);
        bound(sensor_missing_tag_o);
        bound(i >= SENSE_DELAY_MIN * 60 * SEC_SIM - SEC_SIM);
        chk({sensor_error_tag_o, sys_alarm_o}, 2'h3);
        sset(1'b0, 18'h0012C);
        press(3'h2, 3'h4);
        tick(3);
        chk(sys_alarm_o, 1'b1);
        press(3'h2, 3'h3);
        tick(2);
        chk({sys_alarm_o, sensor_missing_tag_o}, 2'h0);
        tick(50);
        chk({sense_en_o, sense_min_o, sense_sec_o}, 13'h0780);
        sset(1'b1, 18'h00100);
        tick(50);
        chk({sense_min_o, sense_sec_o}, 12'h780);
        chk(sense_thresh_o, 18'h00100);
        // second reset in mid-run brings back the defaults
        nrst_i = 1'b0;
        tick(2);
        chk({set_month_o, set_day_o, mode_o, sense_en_o}, 13'h0603);
        nrst_i = 1'b1;
        tick(2);
        chk(sense_thresh_o, 18'h0012C);
        chk({sys_alarm_o, confirm_pending_o}, 2'h0);
        wrap_up();
    end
endmodule
